// ===== dram_power_down_control.sv
// power-down entry/exit control inside the dram device
// Functional notes
// - auto self refresh set: device handles rate itself; extended bit must be zero.
// - power-down entered when clock enable sampled low with nop or deselect.
// - in power-down all buffers off except clock, odt, clock enable, reset.
// - any bank open gives active power-down, else precharge power-down.
// - precharge power-down: dll off for slow exit, on for fast exit.
// - active power-down keeps dll on, exit always fast.
// - slow exit: odt asynchronous from before entry until delay after exit.
// - reset low during power-down forces exit into reset state.
// - exit when clock enable sampled high with nop or deselect.
module dram_power_down_control #(
	parameter int BANKS = 8
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst,
	// dram pins (asynchronous to this clock, synchronised)
	input  wire logic             cke_pin,
	input  wire logic             reset_n_pin,
	input  wire logic [3:0]       cmd_pin,
	// core state
	input  wire logic [BANKS-1:0] bank_open,
	input  wire logic             ops_busy,
	input  wire logic             dll_locked,
	// power-down outputs
	output logic                  buffers_off,
	output logic                  dll_enable,
	output logic                  odt_async,
	output logic                  in_power_down,
	output logic                  self_refresh_auto,
	// apb slave
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic [31:0]           prdata,
	output logic                  pready,
	output logic                  pslverr
);
	logic [1:0] cke_sync_reg;
	logic [1:0] rstn_sync_reg;
	logic [3:0] cmd_s1_reg;
	logic [3:0] cmd_s2_reg;
	logic [31:0] mode_reg;
	logic [7:0]  anpd_reg;
	logic [7:0]  odt_cnt_reg;
	logic        pending_reg;
	logic        unlocked_entry_reg;
	pd_pkg::pd_state_t state_reg;
	logic        cke;
	logic        rstn;
	logic        nop_cmd;
	logic        auto_self_refresh_enable;
	logic        extended_temp_self_refresh;
	logic        fast;
	logic        illegal_sr;

	// deselect (cs high) or nop
	function automatic logic is_quiet(input logic [3:0] c);
		return c[3] || (c == pd_pkg::CMD_NOP);
	endfunction

	// two-stage synchronisers; first stage read only by the second
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cke_sync_reg <= 2'b11;
		end else begin
			cke_sync_reg <= {cke_sync_reg[0], cke_pin};
		end
	end

	// held in reset until a high sampled on the pin has passed through both stages
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rstn_sync_reg <= 2'b00;
		end else begin
			rstn_sync_reg <= {rstn_sync_reg[0], reset_n_pin};
		end
	end

	// command bits take the same two stages so they stay aligned with clock enable
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cmd_s1_reg <= pd_pkg::CMD_NOP;
			cmd_s2_reg <= pd_pkg::CMD_NOP;
		end else begin
			cmd_s1_reg <= cmd_pin;
			cmd_s2_reg <= cmd_s1_reg;
		end
	end
	assign cke  = cke_sync_reg[1];
	assign rstn = rstn_sync_reg[1];
	assign nop_cmd = is_quiet(cmd_s2_reg);

	assign auto_self_refresh_enable  = mode_reg[pd_pkg::MODE_ASR_BIT];
	assign extended_temp_self_refresh  = mode_reg[pd_pkg::MODE_SRT_BIT];
	assign fast = mode_reg[pd_pkg::MODE_FAST_BIT];
	assign illegal_sr = auto_self_refresh_enable && extended_temp_self_refresh;
	// auto refresh rate only honoured when the extended bit is clear
	assign self_refresh_auto = auto_self_refresh_enable && !extended_temp_self_refresh;

	// entry requested while operations run; state decided once they finish
	always_ff @(posedge clk_sys) begin
		if (rst || !rstn) begin
			state_reg          <= pd_pkg::PD_NONE;
			pending_reg        <= 1'b0;
			unlocked_entry_reg <= 1'b0;
		end else if (state_reg == pd_pkg::PD_NONE && !pending_reg) begin
			if (!cke && nop_cmd) begin
				pending_reg        <= 1'b1;
				unlocked_entry_reg <= !dll_locked;
			end
		end else if (pending_reg) begin
			if (cke && nop_cmd) begin
				pending_reg <= 1'b0;
			end else if (!ops_busy) begin
				pending_reg <= 1'b0;
				if (|bank_open) begin
					state_reg <= pd_pkg::PD_ACTIVE;
				end else if (fast) begin
					state_reg <= pd_pkg::PD_PRE_FAST;
				end else begin
					state_reg <= pd_pkg::PD_PRE_SLOW;
				end
			end
		end else if (cke && nop_cmd) begin
			state_reg <= pd_pkg::PD_NONE;
		end
	end

	// odt stays asynchronous for anpd plus dll exit delay after a slow exit
	always_ff @(posedge clk_sys) begin
		if (rst || !rstn) begin
			odt_cnt_reg <= 8'h00;
		end else if (state_reg == pd_pkg::PD_PRE_SLOW) begin
			odt_cnt_reg <= anpd_reg + 8'(pd_pkg::XPDLL_CK);
		end else if (odt_cnt_reg != 8'h00) begin
			odt_cnt_reg <= odt_cnt_reg - 8'h01;
		end
	end

	// outputs registered off the state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			buffers_off <= 1'b0;
		end else begin
			buffers_off <= (state_reg != pd_pkg::PD_NONE);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dll_enable <= 1'b1;
		end else begin
			dll_enable <= (state_reg != pd_pkg::PD_PRE_SLOW);
		end
	end

	// slow-exit entry is predicted at request so odt leads the power-down state
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			odt_async <= 1'b0;
		end else begin
			odt_async <= (state_reg == pd_pkg::PD_PRE_SLOW) || (odt_cnt_reg != 8'h00)
				|| (pending_reg && !fast && !(|bank_open));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			in_power_down <= 1'b0;
		end else begin
			in_power_down <= (state_reg != pd_pkg::PD_NONE);
		end
	end

	// apb registers: zero wait state, unmapped addresses raise pslverr
	logic acc;
	logic wr;
	assign acc = psel && penable;
	assign wr  = acc && pwrite;
	assign pready = 1'b1;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_reg <= pd_pkg::MODE_RESET;
			anpd_reg <= pd_pkg::ANPD_RESET;
		end else if (wr && paddr == pd_pkg::OFF_MODE) begin
			mode_reg <= pwdata;
		end else if (wr && paddr == pd_pkg::OFF_TIMING) begin
			anpd_reg <= pwdata[7:0];
		end
	end

	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		if (paddr == pd_pkg::OFF_MODE) begin
			prdata = mode_reg;
		end else if (paddr == pd_pkg::OFF_STATUS) begin
			prdata[pd_pkg::ST_STATE_LSB +: 2] = state_reg;
			prdata[pd_pkg::ST_DLL_BIT]        = dll_enable;
			prdata[pd_pkg::ST_ODTA_BIT]       = odt_async;
			prdata[pd_pkg::ST_BUFOFF_BIT]     = buffers_off;
			prdata[pd_pkg::ST_SRILL_BIT]      = illegal_sr;
			prdata[6]                         = unlocked_entry_reg;
		end else if (paddr == pd_pkg::OFF_TIMING) begin
			prdata[7:0] = anpd_reg;
		end else begin
			pslverr = acc;
		end
	end
endmodule

// ===== pd_pkg.sv
// constants for the power-down control block
package pd_pkg;
	// apb register byte offsets
	localparam logic [7:0] OFF_MODE   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_TIMING = 8'h08;
	// mode register field positions
	localparam int MODE_ASR_BIT  = 6;
	localparam int MODE_SRT_BIT  = 7;
	localparam int MODE_FAST_BIT = 12;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	// status field positions
	localparam int ST_STATE_LSB  = 0;
	localparam int ST_DLL_BIT    = 2;
	localparam int ST_ODTA_BIT   = 3;
	localparam int ST_BUFOFF_BIT = 4;
	localparam int ST_SRILL_BIT  = 5;
	// timing
	localparam int CLK_PERIOD_PS = 4000;
	localparam int XPDLL_MIN_CK  = 10;
	localparam int XPDLL_NS      = 24;
	localparam int XPDLL_NS_CK   = (XPDLL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int XPDLL_CK      = (XPDLL_NS_CK > XPDLL_MIN_CK) ? XPDLL_NS_CK : XPDLL_MIN_CK;
	localparam logic [7:0] ANPD_RESET = 8'h04;
	// power-down states
	typedef enum logic [1:0] {
		PD_NONE      = 2'b00,
		PD_ACTIVE    = 2'b01,
		PD_PRE_FAST  = 2'b10,
		PD_PRE_SLOW  = 2'b11
	} pd_state_t;
	// command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
endpackage

// ===== pd_checker.sv
// checker for power-down outputs and apb answers
module pd_checker #(parameter int BANKS = 8) (
	input wire logic clk_sys, rst, cke_pin, reset_n_pin, ops_busy, dll_locked,
	input wire logic [3:0] cmd_pin,
	input wire logic [BANKS-1:0] bank_open,
	input wire logic buffers_off, dll_enable, odt_async, in_power_down, self_refresh_auto,
	input wire logic psel, penable, pwrite, pready, pslverr,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata, prdata
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// deselect counts as quiet as well as nop
	wire logic quiet = cmd_pin[3] | (cmd_pin == pd_pkg::CMD_NOP);
	sequence s_enter; (!cke_pin && quiet && !ops_busy && reset_n_pin)[*7]; endsequence
	sequence s_leave; (cke_pin && quiet && reset_n_pin)[*6]; endsequence
	chk_enter_pd: assert property (s_enter |-> in_power_down) else $error("no entry");
	chk_leave_pd: assert property (s_leave |-> !in_power_down) else $error("no exit");
	chk_reset_pd: assert property ((!reset_n_pin)[*5] |-> !in_power_down) else $error("rst");
	chk_buf_state: assert property (buffers_off == in_power_down) else $error("buf");
	chk_dll_slow: assert property (!dll_enable |-> in_power_down && odt_async) else $error("dll");
	chk_active_dll: assert property (in_power_down && |bank_open |-> dll_enable) else $error("act");
	chk_odt_hold: assert property ($rose(dll_enable) |-> odt_async[*8]) else $error("odt");
	chk_apb_ready: assert property (psel && penable |-> pready) else $error("ready");
	chk_apb_err: assert property (psel && penable |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08})) else $error("err");
endmodule
bind dram_power_down_control pd_checker #(.BANKS(BANKS)) u_pd_checker (.*);

// ===== pd_ctrl_model.sv
// controller-side model driving clock enable, command and reset pins
module pd_ctrl_model #(parameter int HOLD = 12) (
	input  wire logic       clk_sys, rst, pd_req, rst_req,
	input  wire logic [3:0] cmd_in,
	output logic            cke_pin, reset_n_pin,
	output logic [3:0]      cmd_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// one quiet span covers every entry and exit delay; slower than needed, never too fast
	logic [7:0] cnt_reg;
	wire logic ready = int'(cnt_reg) >= HOLD;
	wire logic change = ready && (cke_pin == pd_req);
	wire logic issue = ready && cke_pin && !pd_req;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cke_pin <= 1'b1;
			cmd_pin <= pd_pkg::CMD_NOP;
			cnt_reg <= 8'h00;
		end else begin
			cke_pin <= change ? !pd_req : cke_pin;
			cmd_pin <= issue ? cmd_in : pd_pkg::CMD_NOP;
			cnt_reg <= (change || issue) ? 8'h00 : cnt_reg + {7'h0, !ready};
		end
	end
	always_ff @(posedge clk_sys) begin
		reset_n_pin <= rst | !rst_req;
	end
endmodule

// ===== dram_power_down_control_tb.sv
// self-checking bench for the power-down control block
module dram_power_down_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rst = 1, pd_req = 0, rst_req = 0, ops_busy = 0, dll_locked = 1;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, cke_pin, reset_n_pin, err;
	logic buffers_off, dll_enable, odt_async, in_power_down, self_refresh_auto;
	logic [3:0] cmd_pin, cmd_in = 4'h7;
	logic [7:0] paddr = 8'h00, bank_open = 8'h00, seed = 8'h35;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int n_mismatch = 0, tests_run = 0;
	initial forever #2 clk_sys = ~clk_sys;
	dram_power_down_control u_dram_power_down_control (.*);
	pd_ctrl_model u_pd_ctrl_model (.*);
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function logic [6:0] exp_status(input logic open, fast, unl);
		logic slow;
		slow = !open && !fast;
		return {unl, 2'b01, slow, !slow,
			open ? pd_pkg::PD_ACTIVE : fast ? pd_pkg::PD_PRE_FAST : pd_pkg::PD_PRE_SLOW};
	endfunction
	task check(input logic [31:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error t=%0t seen %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge clk_sys);
		penable <= 1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task wait_pd(input logic v);
		while (in_power_down !== v) @(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst <= 0;
		apb(0, pd_pkg::OFF_MODE, 0);
		check(rd, pd_pkg::MODE_RESET);
		apb(0, pd_pkg::OFF_TIMING, 0);
		check(rd, {24'h0, pd_pkg::ANPD_RESET});
		apb(0, 8'h0C, 0);
		check(err, 1);
		for (int i = 0; i < 4; i++) begin
			apb(1, pd_pkg::OFF_MODE, i << 6);
			apb(0, pd_pkg::OFF_STATUS, 0);
			check(self_refresh_auto, i == 1);
			check(rd[5], i == 3);
		end
		for (int k = 0; k < 8; k++) begin
			seed = lfsr(seed);
			bank_open <= k[0] ? seed : 8'h00;
			{dll_locked, ops_busy, cmd_in} <= {seed[1], seed[2], seed[7:4]};
			apb(1, pd_pkg::OFF_MODE, {19'h0, k[1], 12'h0});
			pd_req <= 1;
			repeat (3) @(posedge clk_sys);
			ops_busy <= 0;
			wait_pd(1);
			apb(0, pd_pkg::OFF_STATUS, 0);
			check(rd[6:0], exp_status(k[0], k[1], !dll_locked));
			pd_req <= 0;
			wait_pd(0);
			check(dll_enable, 1);
			$display("test %0d done", k);
		end
		pd_req <= 1;
		wait_pd(1);
		rst_req <= 1;
		repeat (8) @(posedge clk_sys);
		check(in_power_down, 0);
		pd_req <= 0;
		repeat (20) @(posedge clk_sys);
		rst_req <= 0;
		$display("test reset done");
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		stop_test();
	end
endmodule
